//--- hw/power_state_cfg.svh
/*
 * Register offsets, field positions, reset values and codes for the power-state controller.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef POWER_STATE_CFG_SVH
`define POWER_STATE_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define OFS_CPU_CLOCK_CONTROL 8'h04
`define OFS_OSC_CONTROL 8'h08
`define OFS_WAKE_ENABLE 8'h0C
`define OFS_POWER_STATUS 8'h10

// ----------------------------------------------------------------------------
// Field layout and values
// ----------------------------------------------------------------------------
`define CLK_CODE_W 3
`define CLK_CODE_SLEEP 3'h7
`define CLK_CODE_RESET 3'h0
`define OSC_SLOW_ON_BIT 0
`define OSC_CTRL_RESET 2'h1
`define LCD_ON_BIT 1
`define WAKE_ENABLE_RESET 8'h00

`endif

//--- hw/power_state_pkg.sv
/*
 * Types shared by the power-state controller.
 * Assumes the constants header is on the include path.
 */
`default_nettype none
package power_state_pkg;
    `include "power_state_cfg.svh"

    typedef enum logic [2:0] {
        ST_OPERATING = 3'h1,
        ST_HALT = 3'h2,
        ST_STANDBY = 3'h4
    } power_state_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic slow_osc_en;
        logic timers_en;
        logic lcd_en;
        logic io_hold;
        logic ram_retain;
    } power_ctrl_t;
endpackage
`default_nettype wire

//--- hw/power_state_control.sv
/*
 * Power-state controller: operating, halt and standby, CPU clock divider,
 * port-A wake sources, AXI4-Lite register slave.
 * Assumes one clock aclk at 40 MHz, synchronous active-low reset, wake pins
 * synchronous to aclk.
 */
// Decided for this implementation: the AXI4-Lite register port.
`default_nettype none
`include "power_state_cfg.svh"

module power_state_control #(
    parameter int WAKE_PINS = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Wake pins
    input wire logic [WAKE_PINS-1:0] wake_port_pins,
    // Power controls
    output logic cpu_clk_tick,
    output power_state_pkg::power_ctrl_t power_ctrl,
    output power_state_pkg::power_state_t power_state
);
    import power_state_pkg::*;

    // Wake logic is eight bits wide; wider or empty ports cannot be served
    if (WAKE_PINS < 1 || WAKE_PINS > 8) begin : gen_bad_pins
        $error("WAKE_PINS must be 1 to 8");
    end

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic [`CLK_CODE_W-1:0] clk_code;
    logic [1:0] osc_ctrl;
    logic [7:0] wake_enable;
    logic [7:0] wake_prev;
    logic [7:0] wake_seen;
    logic [5:0] div_cnt;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    function automatic logic [6:0] div_mask(input logic [2:0] code);
        // Divide by 2**code; tick when the counter's low bits are all ones
        div_mask = 7'((1 << code) - 1);
    endfunction

    // ------------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------------
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire wr_lane0 = w_strb[0];
    wire wr_clk = wr_go && wr_lane0 && aw_addr == `OFS_CPU_CLOCK_CONTROL;
    wire wr_osc = wr_go && wr_lane0 && aw_addr == `OFS_OSC_CONTROL;
    wire wr_wake = wr_go && wr_lane0 && aw_addr == `OFS_WAKE_ENABLE;
    wire wr_mapped = aw_addr == `OFS_CPU_CLOCK_CONTROL || aw_addr == `OFS_OSC_CONTROL ||
                     aw_addr == `OFS_WAKE_ENABLE || aw_addr == `OFS_POWER_STATUS;
    wire sleep_req = wr_clk && w_data[`CLK_CODE_W-1:0] == `CLK_CODE_SLEEP;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
            s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'h0};
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire [31:0] rd_word =
        rd_addr == `OFS_CPU_CLOCK_CONTROL ? {29'h0, clk_code} :
        rd_addr == `OFS_OSC_CONTROL ? {30'h0, osc_ctrl} :
        rd_addr == `OFS_WAKE_ENABLE ? {24'h0, wake_enable} :
        rd_addr == `OFS_POWER_STATUS ? {21'h0, wake_seen, power_state} : 32'h0;
    wire rd_mapped = rd_addr == `OFS_CPU_CLOCK_CONTROL || rd_addr == `OFS_OSC_CONTROL ||
                     rd_addr == `OFS_WAKE_ENABLE || rd_addr == `OFS_POWER_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_take;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_mapped ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Wake detection
    // ------------------------------------------------------------------------
    wire [7:0] pins_ext = 8'(wake_port_pins);
    wire [7:0] wake_edge = pins_ext & ~wake_prev & wake_enable;
    wire sleeping = power_state != ST_OPERATING;
    wire wake_evt = sleeping && |wake_edge;
    wire slow_on = osc_ctrl[`OSC_SLOW_ON_BIT];

    // ------------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------------
    power_state_t next_state;
    always_comb begin
        next_state = power_state;
        unique case (power_state)
            ST_OPERATING: begin
                if (sleep_req) begin
                    next_state = slow_on ? ST_HALT : ST_STANDBY;
                end
            end
            ST_HALT: begin
                if (wake_evt) begin
                    next_state = ST_OPERATING;
                end
            end
            ST_STANDBY: begin
                if (wake_evt) begin
                    next_state = ST_OPERATING;
                end
            end
            default: next_state = ST_OPERATING;
        endcase
    end

    wire next_op = next_state == ST_OPERATING;
    wire next_halt = next_state == ST_HALT;
    wire [6:0] mask = div_mask(clk_code);
    wire next_tick = next_op && clk_code != `CLK_CODE_SLEEP &&
                     ((7'(div_cnt) & mask) == mask);
    power_ctrl_t next_ctrl;
    always_comb begin
        next_ctrl.cpu_clk_en = next_op;
        next_ctrl.slow_osc_en = next_op || (next_halt && slow_on);
        next_ctrl.timers_en = next_ctrl.slow_osc_en;
        next_ctrl.lcd_en = next_ctrl.slow_osc_en && osc_ctrl[`LCD_ON_BIT];
        next_ctrl.io_hold = next_state == ST_STANDBY;
        next_ctrl.ram_retain = 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_state <= ST_OPERATING;
            clk_code <= `CLK_CODE_RESET;
            osc_ctrl <= `OSC_CTRL_RESET;
            wake_enable <= `WAKE_ENABLE_RESET;
            wake_prev <= 8'h00;
            wake_seen <= 8'h00;
            div_cnt <= 6'h00;
            cpu_clk_tick <= 1'b0;
            power_ctrl <= '0;
        end else begin
            power_state <= next_state;
            wake_prev <= pins_ext;
            div_cnt <= div_cnt + 6'h01;
            cpu_clk_tick <= next_tick;
            power_ctrl <= next_ctrl;
            if (wr_clk) begin
                clk_code <= wake_evt ? `CLK_CODE_RESET : w_data[`CLK_CODE_W-1:0];
            end else if (wake_evt) begin
                clk_code <= `CLK_CODE_RESET;
            end
            if (wr_osc) begin
                osc_ctrl <= w_data[1:0];
            end
            if (wake_evt) begin
                osc_ctrl[`OSC_SLOW_ON_BIT] <= 1'b1;
            end
            if (wr_wake) begin
                wake_enable <= w_data[7:0];
            end
            if (wake_evt) begin
                wake_seen <= wake_edge;
            end else if (sleep_req) begin
                wake_seen <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_standby_entry;
        @(posedge aclk) disable iff (!aresetn)
        (power_state == ST_OPERATING && sleep_req && !slow_on) |=> power_state == ST_STANDBY;
    endproperty
    a_standby_entry: assert property (p_standby_entry) else $error("standby not entered");

    property p_halt_entry;
        @(posedge aclk) disable iff (!aresetn)
        (power_state == ST_OPERATING && sleep_req && slow_on) |=> power_state == ST_HALT;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt not entered");

    property p_halt_no_cpu;
        @(posedge aclk) disable iff (!aresetn)
        (power_state == ST_HALT && !wake_evt) |=> !cpu_clk_tick && !power_ctrl.cpu_clk_en;
    endproperty
    a_halt_no_cpu: assert property (p_halt_no_cpu) else $error("cpu clock in halt");

    property p_standby_off;
        @(posedge aclk) disable iff (!aresetn)
        $rose(power_state == ST_STANDBY) && !wake_evt |=> !power_ctrl.lcd_en && !power_ctrl.slow_osc_en;
    endproperty
    a_standby_off: assert property (p_standby_off) else $error("lcd or osc on in standby");

    property p_standby_hold;
        @(posedge aclk) disable iff (!aresetn)
        (power_state == ST_STANDBY && !wake_evt) |=>
            power_ctrl.io_hold && power_ctrl.ram_retain && !power_ctrl.timers_en;
    endproperty
    a_standby_hold: assert property (p_standby_hold) else $error("standby retention");

    property p_operating_on;
        @(posedge aclk) disable iff (!aresetn)
        (power_state == ST_OPERATING) [*2] |-> power_ctrl.cpu_clk_en && power_ctrl.slow_osc_en;
    endproperty
    a_operating_on: assert property (p_operating_on) else $error("operating clocks off");

    property p_wake_masked;
        @(posedge aclk) disable iff (!aresetn)
        (power_state == ST_HALT && (pins_ext & ~wake_prev & wake_enable) == 8'h00) |=> power_state == ST_HALT;
    endproperty
    a_wake_masked: assert property (p_wake_masked) else $error("woke on masked pin");

    property p_wake_return;
        @(posedge aclk) disable iff (!aresetn)
        wake_evt |=> power_state == ST_OPERATING ##1 power_ctrl.slow_osc_en && power_ctrl.cpu_clk_en;
    endproperty
    a_wake_return: assert property (p_wake_return) else $error("wake not honoured");

    property p_div_spacing;
        @(posedge aclk) disable iff (!aresetn)
        (cpu_clk_tick && clk_code == 3'h1 && power_state == ST_OPERATING && $stable(clk_code)) |=> !cpu_clk_tick;
    endproperty
    a_div_spacing: assert property (p_div_spacing) else $error("divide by 2 broken");

    property p_reset_state;
        @(posedge aclk) !aresetn |=> power_state == ST_OPERATING && !cpu_clk_tick;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule

`default_nettype wire

//--- bench/tb.sv
/*
 * Self-checking bench for the power-state controller.
 * Assumes the package and its constants header are compiled before it.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import power_state_pkg::*;
    `include "power_state_cfg.svh"

    // ---------------------------------------------------------------
    // Stimulus and wiring
    // ---------------------------------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b1;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b1;
    logic [7:0] wake_port_pins = 8'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_clk_tick;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    power_ctrl_t power_ctrl;
    power_state_t power_state;
    int fails = 0;
    int checks_done = 0;

    always #12.5 aclk = ~aclk;

    power_state_control dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wake_port_pins(wake_port_pins),
        .cpu_clk_tick(cpu_clk_tick), .power_ctrl(power_ctrl), .power_state(power_state)
    );

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Response ready stays high, so only the request channels are handshaked here
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic aw_p, w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (aw_p && s_axi_awready === 1'b1) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready === 1'b1) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk("bresp", er, s_axi_bresp);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        chk("rresp", er, s_axi_rresp);
        chk("rdata", exp, s_axi_rdata);
    endtask

    task automatic pulse(input int i);
        wake_port_pins[i] <= 1'b1;
        repeat (2) @(posedge aclk);
        wake_port_pins[i] <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic sleep(input logic [31:0] osc, input logic [31:0] wen);
        wr(`OFS_OSC_CONTROL, osc, 4'hF, 2'h0);
        wr(`OFS_WAKE_ENABLE, wen, 4'hF, 2'h0);
        wr(`OFS_CPU_CLOCK_CONTROL, 32'h7, 4'hF, 2'h0);
        repeat (2) @(posedge aclk);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk("state", ST_OPERATING, power_state);
        chk("ctrl", 6'h39, power_ctrl);
        rd(`OFS_CPU_CLOCK_CONTROL, 32'h0, 2'h0);
        rd(`OFS_OSC_CONTROL, 32'h1, 2'h0);
        rd(`OFS_WAKE_ENABLE, 32'h0, 2'h0);
        $display("test reset done");
    endtask

    task automatic t_divider();
        int n;
        for (int code = 0; code < 7; code++) begin
            wr(`OFS_CPU_CLOCK_CONTROL, code, 4'hF, 2'h0);
            repeat (2) do @(posedge aclk); while (cpu_clk_tick !== 1'b1);
            n = 0;
            do begin
                @(posedge aclk);
                n++;
            end while (cpu_clk_tick !== 1'b1);
            chk("tick_gap", 32'h1 << code, n);
        end
        $display("test divider done");
    endtask

    task automatic t_halt();
        int n;
        sleep(32'h3, 32'h08);
        chk("state", ST_HALT, power_state);
        chk("ctrl", 6'h1D, power_ctrl);
        n = 0;
        repeat (80) begin
            @(posedge aclk);
            if (cpu_clk_tick !== 1'b0) n++;
        end
        chk("halt_ticks", 0, n);
        rd(`OFS_CPU_CLOCK_CONTROL, 32'h7, 2'h0);
        pulse(0);
        chk("state", ST_HALT, power_state);
        pulse(3);
        chk("state", ST_OPERATING, power_state);
        chk("ctrl", 6'h3D, power_ctrl);
        rd(`OFS_CPU_CLOCK_CONTROL, 32'h0, 2'h0);
        rd(`OFS_POWER_STATUS, 32'h41, 2'h0);
        $display("test halt done");
    endtask

    task automatic t_standby();
        sleep(32'h0, 32'h80);
        chk("state", ST_STANDBY, power_state);
        chk("ctrl", 6'h03, power_ctrl);
        pulse(3);
        chk("state", ST_STANDBY, power_state);
        pulse(7);
        chk("state", ST_OPERATING, power_state);
        rd(`OFS_OSC_CONTROL, 32'h1, 2'h0);
        rd(`OFS_POWER_STATUS, 32'h401, 2'h0);
        $display("test standby done");
    endtask

    task automatic t_bus();
        rd(8'h20, 32'h0, 2'h2);
        wr(8'h20, 32'h5, 4'hF, 2'h2);
        wr(`OFS_WAKE_ENABLE, 32'hFF, 4'hE, 2'h0);
        rd(`OFS_WAKE_ENABLE, 32'h80, 2'h0);
        $display("test bus done");
    endtask

    task automatic t_midreset();
        sleep(32'h1, 32'h01);
        chk("state", ST_HALT, power_state);
        chk("ctrl", 6'h19, power_ctrl);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("state", ST_OPERATING, power_state);
        chk("ctrl", 6'h00, power_ctrl);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(`OFS_CPU_CLOCK_CONTROL, 32'h0, 2'h0);
        rd(`OFS_WAKE_ENABLE, 32'h0, 2'h0);
        $display("test midreset done");
    endtask

    // ---------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ---------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_divider();
        t_halt();
        t_standby();
        t_bus();
        t_midreset();
        finish_test();
    end
endmodule
`default_nettype wire
